// >>> rtl/fts_fan_super.v
// Per-fan stall, spin-up, drive-fail and tach measurement logic.
// Assumes all inputs are synchronous to clk; ref_tick is one pulse per reference period.
// Function
// RL1: Stall when tach count exceeds valid limit
// RL2: Closed-loop stall starts spin-up automatically
// RL3: Target above limit keeps present drive
// RL4: Stall sets flag and raises interrupt
// RL5: Closed loop retries until tach valid
// RL6: Mask stall during programmed spin-up time
// RL7: Direct mode flags stall on over-limit count
// RL8: Closed-loop stall checked only at update
// RL9: Unreachable target at full drive flags fail
// RL10: Drive-fail select: off, 16, 32, 64
// RL11: Pull-up code sets default drive levels
// RL12: Reference selectable external or internal clock
// RL13: Clock-out mode drives internal clock push-pull; here the pin is driven only while pu_enable is low
// RL14: Direct drive 00h to nonzero starts spin
// RL15: Target leaving FFh below limit starts spin
// RL16: Optional full kick first quarter, then level
// RL17: Spin level codes 30% to 65%
// RL18: Spin time 250 ms to 2 s
// RL19: Failed spin-up flags and repeats attempt
// RL20: Nonzero default drive applied without spin-up
// RL21: Count reference periods over 3-9 edges
// RL22: Closed loop floors at minimum drive
// RL23: Tach counter saturates when fan stopped
`include "fts_regs.vh"
module fts_fan_super #(
   parameter CW = 16, // Tach counter width
   parameter SPIN_UNIT = `FTS_CLK_HZ / 4 // Cycles per 250 ms, a quarter second
) (
   input wire clk,
   input wire rstn,
   input wire tach_input, // Fan tach, synchronous
   input wire ref_int_tick, // Internal 32 kHz reference tick
   input wire clk_pin_in, // Clock pin level from outside
   input wire clk_ext_sel, // Use external reference on clock pin
   input wire clk_out_en, // Clock-out mode
   input wire int_osc, // Internal oscillator level
   input wire loop_en, // Closed-loop algorithm enabled
   input wire update_tick, // Update-time pulse
   input wire [7:0] direct_drive, // Direct mode drive setting
   input wire [7:0] loop_drive, // Drive from closed-loop calculation
   input wire [7:0] min_drive, // Closed-loop minimum drive
   input wire [7:0] target_count, // Target tach count, zero-extended as the low byte
   input wire [CW-1:0] valid_limit, // Valid tach count limit
   input wire [CW-1:0] band, // Drive-fail tach band
   input wire [2:0] spin_level_select,
   input wire [1:0] spin_time_select,
   input wire spin_kick_en, // Full-scale first quarter
   input wire [1:0] edge_count_select,
   input wire [1:0] drive_fail_period_select,
   input wire pu_enable, // Address decode enables pull-up default
   input wire [2:0] pu_code, // Decoded clock-pin pull-up
   input wire stall_clr, // Clear stall flag
   input wire spin_clr, // Clear spin-fail flag
   input wire df_clr, // Clear drive-fail flag
   output reg [7:0] drive_out,
   output reg [CW-1:0] tach_count,
   output reg stall_status_flag,
   output reg spin_fail_flag,
   output reg drive_fail_flags,
   output reg irq_out, // Stall interrupt
   output reg alert_out, // Drive-fail alert
   output reg spin_active,
   output reg clk_pin_out,
   output reg clk_pin_oe
);
   // ==========================================
   // Functions
   // ==========================================
   // Percent of full scale to 8-bit drive
   function [7:0] pct;
      input [6:0] p;
      reg [15:0] t;
      begin
         // Scale to 255 first so small percentages keep their precision
         t = {9'h000, p} * 16'h00FF;
         t = t / 16'h0064;
         // Quotient stays within 255 only for p up to 100, the low byte is the whole result
         pct = t[7:0];
      end
   endfunction
   // Stall compare against limit
   function over;
      input [CW-1:0] c;
      input [CW-1:0] l;
      begin
         over = (c > l);
      end
   endfunction
   // Shortest spin time; longer codes double it
   localparam [31:0] SPIN_T0 = SPIN_UNIT * (`FTS_SPIN_MS_0 / `FTS_SPIN_MS_0);
   // State codes, one-hot
   localparam [2:0] S_RUN = 3'h1;
   localparam [2:0] S_KICK = 3'h2;
   localparam [2:0] S_LEVEL = 3'h4;

   // ==========================================
   // Reference selection and clock pin
   // ==========================================
   reg ref_pin_d_r; // Previous clock-pin level
   reg tach_d_r; // Previous tach level
   // Rising edge of an outside clock on the pin; ignored while we drive it
   wire ext_tick = clk_ext_sel & ~clk_out_en & clk_pin_in & ~ref_pin_d_r;
   // RL12: reference source select
   wire ref_tick = (clk_ext_sel & ~clk_out_en) ? ext_tick : ref_int_tick;
   // RL13: push-pull clock out
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_pin_out <= 1'b0;
         clk_pin_oe <= 1'b0;
         // Pin idles high on its pull-up, so no false edge after reset
         ref_pin_d_r <= 1'b1;
      end else begin
         clk_pin_out <= clk_out_en & int_osc;
         // Pin is a strap input when the pull-up decode owns it
         clk_pin_oe <= clk_out_en & ~pu_enable;
         ref_pin_d_r <= clk_pin_in;
      end
   end

   // ==========================================
   // Tach measurement
   // ==========================================
   reg [CW-1:0] cnt_r; // Reference periods in window
   reg [3:0] edge_r; // Edges seen in window
   wire tach_edge = tach_input ^ tach_d_r;
   // RL21: edges per window 3,5,7,9
   wire [3:0] edge_need = {1'b0, edge_count_select, 1'b0} + 4'h3;
   wire cnt_max = &cnt_r;
   // Count including a tick that lands on an edge cycle, held at the ceiling
   wire [CW-1:0] cnt_sum = cnt_r + {{(CW-1){1'b0}}, ref_tick & ~cnt_max};

   // Count periods between first and last edge
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Tach idles high on its pull-up
         tach_d_r <= 1'b1;
         cnt_r <= {CW{1'b0}};
         edge_r <= 4'h0;
         tach_count <= {CW{1'b1}};
      end else begin
         tach_d_r <= tach_input;
         if (tach_edge) begin
            if (edge_r == 4'h0) begin
               // First edge opens the window
               edge_r <= 4'h1;
               cnt_r <= {CW{1'b0}};
            end else if (edge_r + 4'h1 >= edge_need) begin
               // Window complete, publish and restart
               // A tick on this edge still belongs to the closing window
               tach_count <= cnt_sum;
               edge_r <= 4'h1;
               cnt_r <= {CW{1'b0}};
            end else begin
               // Middle edge, keep counting without losing a tick
               edge_r <= edge_r + 4'h1;
               cnt_r <= cnt_sum;
            end
         end else if (ref_tick && !cnt_max) begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
         end else if (cnt_max) begin
            // RL23: saturate on stopped fan
            tach_count <= {CW{1'b1}};
            edge_r <= 4'h0;
         end
      end
   end

   // ==========================================
   // Spin-up sequencer
   // ==========================================
   reg [2:0] st_r; // Sequencer state
   reg [31:0] tmr_r; // Spin time counter
   reg [7:0] dd_d_r; // Previous direct drive
   reg [7:0] tgt_d_r; // Previous target
   reg pu_done_r; // Power-up default taken
   reg [7:0] pu_drv_r; // Power-up default drive
   wire [31:0] total = SPIN_T0 << spin_time_select; // RL18: 250 ms doubling
   wire [31:0] quarter = total >> 2;
   wire tach_bad = over(tach_count, valid_limit);
   // RL14: direct zero to nonzero
   wire dir_start = ~loop_en & (dd_d_r == `FTS_DRV_ZERO) & (direct_drive != `FTS_DRV_ZERO);
   // RL15: target leaves off value
   wire tgt_start = loop_en & (tgt_d_r == `FTS_TARGET_OFF) & (target_count != `FTS_TARGET_OFF) &
                    ({{(CW-8){1'b0}}, target_count} < valid_limit);
   // RL2: closed-loop stall at update
   wire loop_stall = loop_en & update_tick & tach_bad;
   // Starts only from idle; requests while spinning are refused
   wire start = (st_r == S_RUN) & (dir_start | tgt_start | loop_stall);
   // Last cycle of the programmed spin time
   wire spin_end = (st_r != S_RUN) & (tmr_r >= total - 32'h1);
   // RL17: 30% plus 5% per code
   wire [7:0] lvl = pct({4'h0, spin_level_select} * 7'h05 + 7'h1E);
   // Sequencer state machine
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= S_RUN;
         tmr_r <= 32'h0;
         dd_d_r <= `FTS_DRV_ZERO;
         tgt_d_r <= `FTS_TARGET_OFF;
      end else begin
         dd_d_r <= direct_drive;
         tgt_d_r <= target_count;
         case (st_r)
            S_RUN: begin
               tmr_r <= 32'h0;
               // Take a start request, kick first if asked
               if (start) begin
                  st_r <= spin_kick_en ? S_KICK : S_LEVEL;
               end
            end
            S_KICK: begin
               tmr_r <= tmr_r + 32'h1;
               // RL16: kick for first quarter
               if (tmr_r >= quarter - 32'h1) begin
                  st_r <= S_LEVEL;
               end
            end
            S_LEVEL: begin
               tmr_r <= tmr_r + 32'h1;
               if (spin_end) begin
                  // RL19: retry on failed spin
                  // RL5: retry while loop enabled
                  if (tach_bad && (loop_en || direct_drive != `FTS_DRV_ZERO)) begin
                     st_r <= spin_kick_en ? S_KICK : S_LEVEL;
                     tmr_r <= 32'h0;
                  end else begin
                     // Fan turning or drive withdrawn, spin-up done
                     st_r <= S_RUN;
                  end
               end
            end
            default: begin
               // Unknown code falls back to idle
               st_r <= S_RUN;
            end
         endcase
      end
   end

   // ==========================================
   // Power-up default drive
   // ==========================================
   // RL11: pull-up decode table
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pu_done_r <= 1'b0;
         pu_drv_r <= `FTS_DRV_ZERO;
      end else begin
         if (!pu_done_r) begin
            // Strap is read once, on the first edge after reset
            pu_done_r <= 1'b1;
            case (pu_code)
               `FTS_PU_30: pu_drv_r <= pu_enable ? pct(7'h1E) : `FTS_DRV_ZERO;
               `FTS_PU_50: pu_drv_r <= pu_enable ? pct(7'h32) : `FTS_DRV_ZERO;
               `FTS_PU_75: pu_drv_r <= pu_enable ? pct(7'h4B) : `FTS_DRV_ZERO;
               `FTS_PU_100: pu_drv_r <= pu_enable ? `FTS_DRV_FULL : `FTS_DRV_ZERO;
               // Off codes, and no strap at all
               default: pu_drv_r <= `FTS_DRV_ZERO;
            endcase
         end else if (loop_en || direct_drive != `FTS_DRV_ZERO) begin
            // Software takes over from the default
            pu_drv_r <= `FTS_DRV_ZERO;
         end
      end
   end

   // ==========================================
   // Drive output
   // ==========================================
   reg [7:0] drv_nxt;
   // Drive selection
   always @* begin
      drv_nxt = direct_drive;
      if (st_r == S_KICK) begin
         drv_nxt = `FTS_DRV_FULL;
      end else if (st_r == S_LEVEL) begin
         drv_nxt = lvl;
      end else if (loop_en) begin
         // RL3: ignore target over limit
         if ({{(CW-8){1'b0}}, target_count} > valid_limit) begin
            drv_nxt = drive_out;
         end else if (target_count == `FTS_TARGET_OFF) begin
            drv_nxt = `FTS_DRV_ZERO;
         end else if (loop_drive < min_drive) begin
            // RL22: minimum drive floor
            drv_nxt = min_drive;
         end else begin
            drv_nxt = loop_drive;
         end
      end else if (pu_drv_r != `FTS_DRV_ZERO) begin
         // RL20: default applied, no spin-up
         drv_nxt = pu_drv_r;
      end
   end
   // Registered drive and spin indicator
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drive_out <= `FTS_DRV_ZERO;
         spin_active <= 1'b0;
      end else begin
         drive_out <= drv_nxt;
         // Rises with the start edge, trails the sequencer by one cycle
         spin_active <= (st_r != S_RUN) | start;
      end
   end

   // ==========================================
   // Status flags
   // ==========================================
   reg [6:0] df_cnt_r; // Update periods at full drive out of band
   wire [6:0] df_need = 7'h08 << drive_fail_period_select; // RL10: 16/32/64
   // RL6: mask during spin-up
   wire masked = (st_r != S_RUN);
   // RL1: over-limit count is a stall
   // RL7: direct mode continuous check
   // RL8: loop mode checked at update
   wire stall_ev = ~masked & tach_bad & (loop_en ? update_tick : 1'b1);
   // At full drive yet slower than target plus band
   wire df_cond = loop_en & (drive_out == `FTS_DRV_FULL) &
                  (tach_count > {{(CW-8){1'b0}}, target_count} + band);
   // Sticky flags, set beats clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stall_status_flag <= 1'b0;
         spin_fail_flag <= 1'b0;
         drive_fail_flags <= 1'b0;
         irq_out <= 1'b0;
         alert_out <= 1'b0;
         df_cnt_r <= 7'h00;
      end else begin
         // RL4: flag and interrupt
         stall_status_flag <= stall_ev | (stall_status_flag & ~stall_clr);
         irq_out <= stall_ev | (stall_status_flag & ~stall_clr);
         // Spin fail on a slow tach at the end of a spin
         spin_fail_flag <= (spin_end & tach_bad) | (spin_fail_flag & ~spin_clr);
         // RL9: drive-fail after period
         if (drive_fail_period_select == 2'h0 || !df_cond) begin
            df_cnt_r <= 7'h00;
         end else if (update_tick && df_cnt_r < df_need) begin
            df_cnt_r <= df_cnt_r + 7'h01;
         end
         // Counter full and detection enabled
         drive_fail_flags <= (df_cnt_r >= df_need && df_need != 7'h08) | (drive_fail_flags & ~df_clr);
         alert_out <= (df_cnt_r >= df_need && df_need != 7'h08) | (drive_fail_flags & ~df_clr);
      end
   end
endmodule // fts_fan_super

// >>> rtl/fts_regs.vh
// Constants for the fan tach, stall and spin-up supervisor.
// Assumes a 25 MHz system clock and a one-cycle tach reference tick input.
`ifndef FTS_REGS_VH
`define FTS_REGS_VH
// ==========================================
// Clock and timing
// ==========================================
`define FTS_CLK_HZ 25000000
`define FTS_SPIN_MS_0 250
`define FTS_SPIN_MS_1 500
`define FTS_SPIN_MS_2 1000
`define FTS_SPIN_MS_3 2000
// ==========================================
// Reset values of configuration fields
// ==========================================
`define FTS_SPIN_LEVEL_RST 3'h6
`define FTS_SPIN_TIME_RST 2'h1
`define FTS_EDGE_SEL_RST 2'h1
`define FTS_DF_SEL_RST 2'h0
// ==========================================
// Drive levels, 8-bit full scale
// ==========================================
`define FTS_DRV_FULL 8'hFF
`define FTS_DRV_ZERO 8'h00
`define FTS_TARGET_OFF 8'hFF
// ==========================================
// Pull-up decode codes
// ==========================================
`define FTS_PU_0 3'h0
`define FTS_PU_30 3'h1
`define FTS_PU_50 3'h2
`define FTS_PU_75 3'h3
`define FTS_PU_100 3'h4
`define FTS_PU_OFF 3'h5
`endif

// >>> test/fts_fan_model.sv
// Behavioural four-wire fan: tach toggles while driven.
// Assumes drive is the supervisor output; stop seizes the rotor.
module fts_fan_model #(
   parameter HALF = 4
) (
   input wire clk,
   input wire rstn,
   input wire [7:0] drive,
   input wire stop,
   output logic tach
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt; // Cycles since last tach edge
   // Stopped rotor leaves the open-drain tach at its pull-up
   always @(posedge clk or negedge rstn) begin
      if (!rstn || drive == 8'h00 || stop) begin
         cnt <= 0;
         tach <= 1'b1;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         tach <= ~tach;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // fts_fan_model

// >>> test/fts_fan_super_chk.sv
// Port checker for the fan supervisor.
// Assumes one clock, clk, and the active-low reset rstn.
module fts_chk #(
   parameter CW = 16
) (
   input wire clk,
   input wire rstn,
   input wire spin_kick_en,
   input wire [2:0] spin_level_select,
   input wire [7:0] drive_out,
   input wire spin_active,
   input wire stall_status_flag,
   input wire irq_out,
   input wire drive_fail_flags,
   input wire alert_out,
   input wire spin_fail_flag,
   input wire [CW-1:0] tach_count,
   input wire [CW-1:0] valid_limit,
   input wire clk_pin_oe,
   input wire clk_out_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Spin level code to 8-bit drive
   function automatic logic [7:0] lvl(input logic [2:0] s);
      return 8'(((30 + 5 * s) * 255) / 100);
   endfunction
   chk_kick_full: assert property ($rose(spin_active) && spin_kick_en |=> drive_out == 8'hFF)
      else $error("kick drive not full scale");
   chk_spin_level: assert property ($rose(spin_active) && !spin_kick_en |=> drive_out == lvl($past(spin_level_select)))
      else $error("spin drive level wrong");
   chk_stall_mask: assert property (spin_active && $past(spin_active) |-> !$rose(stall_status_flag))
      else $error("stall raised during spin");
   chk_stall_cause: assert property ($rose(stall_status_flag) |-> $past(tach_count) > $past(valid_limit))
      else $error("stall without slow tach");
   chk_irq_follow: assert property ($rose(stall_status_flag) |-> ##[0:1] irq_out)
      else $error("stall gave no interrupt");
   chk_alert_follow: assert property ($rose(drive_fail_flags) |-> ##[0:1] alert_out)
      else $error("drive fail gave no alert");
   chk_spin_fail: assert property ($rose(spin_fail_flag) |-> $past(tach_count) > $past(valid_limit))
      else $error("spin fail with valid tach");
   chk_clk_drive: assert property ($rose(clk_pin_oe) |-> $past(clk_out_en))
      else $error("clock pin driven outside clock-out mode");
   cover property ($rose(spin_active));
   cover property ($rose(spin_fail_flag));
   cover property ($rose(drive_fail_flags));
endmodule // fts_chk
bind fts_fan_super fts_chk #(.CW(CW)) i_chk (.*);

// >>> test/fts_fan_super_tb.sv
// Self-checking bench for fts_fan_super with a fan model.
// Assumes short spin unit SU and a 10-bit tach counter.
module fts_fan_super_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam CW = 10;
   localparam SU = 40;
   logic clk, rstn, tach_input, ref_int_tick, clk_pin_in, clk_ext_sel, clk_out_en, int_osc, loop_en, update_tick;
   logic spin_kick_en, pu_enable, stall_clr, spin_clr, df_clr, stop, spin_active, clk_pin_out, clk_pin_oe;
   logic stall_status_flag, spin_fail_flag, drive_fail_flags, irq_out, alert_out;
   logic [7:0] direct_drive, loop_drive, min_drive, target_count, drive_out;
   logic [CW-1:0] valid_limit, band, tach_count;
   logic [2:0] spin_level_select, pu_code;
   logic [1:0] spin_time_select, edge_count_select, drive_fail_period_select;
   logic [31:0] lfsr = 32'hFE049EAA, r;
   int err_count = 0, total_checks = 0, n, cyc = 0;
   fts_fan_super #(.CW(CW), .SPIN_UNIT(SU)) i_dut (.*);
   fts_fan_model i_fan (.clk(clk), .rstn(rstn), .drive(drive_out), .stop(stop), .tach(tach_input));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Reference ticks, update pulses and pin clock
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ref_int_tick <= cyc[0];
      update_tick <= cyc[2:0] == 3'h7;
      int_osc <= cyc[3];
      clk_pin_in <= cyc[4];
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [7:0] pu_drv(input int c);
      return 8'((c == 1 ? 30 : c == 2 ? 50 : c == 3 ? 75 : c == 4 ? 100 : 0) * 255 / 100);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Bounded wait for spin_active; n counts cycles
   task automatic wait_spin(input logic v, input int lim);
      n = 0;
      while (spin_active !== v && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      chk(spin_active, v);
      if (spin_active !== v) end_of_test();
   endtask
   task automatic do_reset(input int c, input logic en);
      @(posedge clk);
      {rstn, pu_code, pu_enable} <= {1'b0, c[2:0], en};
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
   endtask
   initial begin
      {rstn, clk_ext_sel, clk_out_en, loop_en, spin_kick_en, pu_enable, stall_clr, spin_clr, df_clr, stop} = '0;
      {band, pu_code, spin_time_select} = '0;
      {direct_drive, loop_drive, min_drive, drive_fail_period_select} = '0;
      {target_count, valid_limit, spin_level_select, edge_count_select} = {8'hFF, 10'h064, 3'h6, 2'h1};
      for (int c = 0; c < 6; c++) begin
         do_reset(c, 1'b1);
         repeat (4) @(posedge clk);
         #1 chk(drive_out, pu_drv(c));
         chk(spin_active, 1'b0);
      end
      do_reset(0, 1'b0);
      repeat (2200) @(posedge clk);
      #1 chk(tach_count, 10'h3FF);
      chk(stall_status_flag, 1'b1);
      chk(irq_out, 1'b1);
      @(posedge clk);
      {stop, direct_drive} <= {1'b1, 8'h33};
      wait_spin(1'b1, 4);
      repeat (SU + 4) @(posedge clk);
      #1 chk(spin_fail_flag, 1'b1);
      chk(spin_active, 1'b1);
      @(posedge clk);
      stop <= 1'b0;
      wait_spin(1'b0, 3 * SU);
      @(posedge clk);
      {spin_clr, stall_clr} <= 2'h3;
      @(posedge clk);
      {spin_clr, stall_clr} <= 2'h0;
      repeat (2) @(posedge clk);
      #1 chk(spin_fail_flag, 1'b0);
      chk(stall_status_flag, 1'b0);
      for (int e = 0; e < 4; e++) begin
         @(posedge clk);
         edge_count_select <= e[1:0];
         repeat (100) @(posedge clk);
         #1 chk(tach_count + 1 - (4 + 4 * e) <= 2, 1'b1);
      end
      for (int t = 0; t < 4; t++) begin
         r = rnd();
         @(posedge clk);
         {direct_drive, spin_time_select, spin_kick_en, spin_level_select} <= {8'h00, t[1:0], r[3:0]};
         repeat (4) @(posedge clk);
         direct_drive <= r[15:8] | 8'h01;
         wait_spin(1'b1, 4);
         wait_spin(1'b0, 8 * SU + 8);
         // Spin lasts the programmed time; the flag trails it by one cycle
         chk(n, (SU << t) + 1);
      end
      @(posedge clk);
      {loop_en, loop_drive} <= {1'b1, 8'hFF};
      @(posedge clk);
      target_count <= 8'h00;
      wait_spin(1'b1, 4);
      wait_spin(1'b0, 8 * SU + 8);
      for (int d = 1; d < 4; d++) begin
         @(posedge clk);
         {drive_fail_period_select, df_clr, loop_drive} <= {2'h0, 1'b1, 8'h80};
         repeat (16) @(posedge clk);
         {drive_fail_period_select, df_clr, loop_drive} <= {d[1:0], 1'b0, 8'hFF};
         repeat ((64 << d) - 24) @(posedge clk);
         #1 chk(drive_fail_flags, 1'b0);
         repeat (48) @(posedge clk);
         #1 chk(drive_fail_flags, 1'b1);
         chk(alert_out, 1'b1);
      end
      @(posedge clk);
      {drive_fail_period_select, df_clr} <= 3'h1;
      @(posedge clk);
      df_clr <= 1'b0;
      repeat (600) @(posedge clk);
      #1 chk(drive_fail_flags, 1'b0);
      @(posedge clk);
      {min_drive, loop_drive} <= 16'h4010;
      repeat (24) @(posedge clk);
      #1 chk(drive_out, 8'h40);
      @(posedge clk);
      clk_ext_sel <= 1'b1;
      repeat (100) @(posedge clk);
      // Nine edges span 32 cycles; the pin clock rises once every 32 cycles
      #1 chk(tach_count, 10'h001);
      @(posedge clk);
      clk_ext_sel <= 1'b0;
      @(posedge clk);
      stop <= 1'b1;
      wait_spin(1'b1, 2400);
      chk(tach_count, 10'h3FF);
      chk(stall_status_flag, 1'b1);
      @(posedge clk);
      clk_out_en <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(clk_pin_oe, 1'b1);
      for (int k = 0; k < 16; k++) begin
         r[0] = int_osc;
         @(posedge clk);
         #1 chk(clk_pin_out, r[0]);
      end
      end_of_test();
   end
endmodule // fts_fan_super_tb
